// [fpsm_defs.svh]
`ifndef FPSM_DEFS_SVH
`define FPSM_DEFS_SVH

// encodings of the power_state_field (2 bits)
`define FPSM_PS_D0 2'h0
`define FPSM_PS_D1 2'h1
`define FPSM_PS_D2 2'h2
`define FPSM_PS_D3 2'h3

// recovery times and clock rate
`define FPSM_CLK_MHZ 250
`define FPSM_D2_REC_US 200
`define FPSM_D3_REC_MS 10
`define FPSM_D2_REC_CYC (`FPSM_D2_REC_US * `FPSM_CLK_MHZ)
`define FPSM_D3_REC_CYC (`FPSM_D3_REC_MS * 1000 * `FPSM_CLK_MHZ)

// soft reset length in cycles
`define FPSM_SOFT_RST_CYC 16

`endif

// [fpsm_pkg.sv]
package fpsm_pkg;
  typedef enum logic [2:0] {
    FPSM_D0_UNINIT,
    FPSM_D0_ACTIVE,
    FPSM_D1,
    FPSM_D2,
    FPSM_D3_HOT,
    FPSM_D3_COLD,
    FPSM_OFF
  } fpsm_state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] state;
  } fpsm_ps_wr_t;

  typedef struct packed {
    logic mem_en;
    logic io_en;
    logic master_en;
  } fpsm_enables_t;
endpackage

// [fpsm_counter.sv]
`timescale 1ns/1ns
module fpsm_counter #(
  parameter int WIDTH = 24
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_busy
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic busy_q;
  logic busy_d;

  assign count_d = i_load ? i_value :
                   (count_q != '0) ? count_q - 1'b1 : count_q;
  assign busy_d = i_load ? (i_value != '0) : (count_q > 1);
  assign o_busy = busy_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q <= busy_d;
    end
  end
endmodule

// [fpsm_power_state_machine.sv]
`timescale 1ns/1ns
`include "fpsm_defs.svh"

// Functional notes
// - state moves on a software write to the power state field, a bus reset, power loss, an enable or soft reset end; hardware reset forces D0 uninitialized.
// - allowed software moves are D0u to D3, D0a to D1/D2/D3, D1 to D0/D2/D3, D2 to D0/D3, D3hot to D0u, none from D3cold.
// - a bus segment reset returns any state to D0 uninitialized; power removal takes any state to Off, save D3hot/D3cold, which go to D3cold while aux power stays.
// - restore time to D0 active counts from a control/status write or from a bus segment reset.
// - during D3hot to D0 the bus drivers behave as after the card reset.
// - D0 uninitialized becomes D0 active once memory, I/O or bus master enable is set.
// - a write from D3hot to D0 runs an internal soft reset keeping only wake-event context, ending in D0 uninitialized.
module fpsm_power_state_machine #(
  parameter int D2_REC_CYC = `FPSM_D2_REC_CYC,
  parameter int D3_REC_CYC = `FPSM_D3_REC_CYC,
  parameter int SOFT_RST_CYC = `FPSM_SOFT_RST_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_bus_rst,
  input wire logic i_main_pwr,
  input wire logic i_aux_pwr,
  input wire fpsm_pkg::fpsm_ps_wr_t i_ps_wr,
  input wire fpsm_pkg::fpsm_enables_t i_enables,
  input wire logic i_wake_event_enable,
  input wire logic i_wake_event,
  output fpsm_pkg::fpsm_state_t o_state,
  output logic [1:0] o_power_state_field,
  output logic o_drivers_off,
  output logic o_soft_rst,
  output logic o_recovering,
  output logic o_restoring,
  output logic o_wake_event_enable,
  output logic o_wake_status
);
  import fpsm_pkg::*;

  localparam int CW = 24;

  fpsm_state_t state_q;
  fpsm_state_t state_d;
  logic [1:0] field_q;
  logic [1:0] field_d;
  logic soft_q;
  logic soft_d;
  logic drv_off_q;
  logic restoring_q;
  logic restoring_d;
  logic wake_en_q;
  logic wake_en_d;
  logic wake_st_q;
  logic wake_st_d;
  logic [CW-1:0] soft_cnt_q;
  logic [CW-1:0] soft_cnt_d;
  logic rec_busy;
  logic rec_load;
  logic [CW-1:0] rec_value;

  // decode of the requested move
  wire [1:0] req = i_ps_wr.state;
  wire wr = i_ps_wr.valid && i_main_pwr && !soft_q;
  wire any_en = i_enables.mem_en | i_enables.io_en | i_enables.master_en;
  wire req_d0 = (req == `FPSM_PS_D0);
  wire req_d1 = (req == `FPSM_PS_D1);
  wire req_d2 = (req == `FPSM_PS_D2);
  wire req_d3 = (req == `FPSM_PS_D3);
  wire ok_d0u = req_d3;
  wire ok_d0a = req_d1 | req_d2 | req_d3;
  wire ok_d1 = req_d0 | req_d2 | req_d3;
  wire ok_d2 = req_d0 | req_d3;
  wire ok_d3h = req_d0;
  wire legal = wr && (
    (state_q == FPSM_D0_UNINIT && ok_d0u) ||
    (state_q == FPSM_D0_ACTIVE && ok_d0a) ||
    (state_q == FPSM_D1 && ok_d1) ||
    (state_q == FPSM_D2 && ok_d2) ||
    (state_q == FPSM_D3_HOT && ok_d3h));
  // only the D2 to D0 move earns the long window, D2 to D3 does not
  wire from_d2_d0 = legal && req_d0 && state_q == FPSM_D2;
  wire from_d3_d0 = legal && state_q == FPSM_D3_HOT;
  wire soft_done = soft_q && (soft_cnt_q == '0);

  // recovery window after each accepted write, 10 ms / 200 us for wakeups
  assign rec_load = legal;
  assign rec_value = from_d3_d0 ? CW'(D3_REC_CYC) :
                     from_d2_d0 ? CW'(D2_REC_CYC) : CW'(1);

  fpsm_counter #(.WIDTH(CW)) u_rec (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst | i_bus_rst),
    .i_load(rec_load),
    .i_value(rec_value),
    .o_busy(rec_busy)
  );

  // next state: power loss beats bus reset beats software
  always_comb begin
    state_d = state_q;
    if (!i_main_pwr) begin
      if (state_q == FPSM_D3_HOT || state_q == FPSM_D3_COLD)
        state_d = i_aux_pwr ? FPSM_D3_COLD : FPSM_OFF;
      else
        state_d = FPSM_OFF;
    end else if (i_bus_rst) begin
      state_d = FPSM_D0_UNINIT;
    end else if (soft_q) begin
      if (soft_done)
        state_d = FPSM_D0_UNINIT;
    end else if (state_q == FPSM_OFF || state_q == FPSM_D3_COLD) begin
      // power back without a bus reset: wait for the reset
      state_d = state_q;
    end else if (legal) begin
      case (state_q)
        FPSM_D0_UNINIT: state_d = FPSM_D3_HOT;
        FPSM_D3_HOT: state_d = FPSM_D3_HOT; // held by soft reset
        default: begin
          case (req)
            `FPSM_PS_D0: state_d = FPSM_D0_ACTIVE;
            `FPSM_PS_D1: state_d = FPSM_D1;
            `FPSM_PS_D2: state_d = FPSM_D2;
            default: state_d = FPSM_D3_HOT;
          endcase
        end
      endcase
    end else if (state_q == FPSM_D0_UNINIT && any_en) begin
      state_d = FPSM_D0_ACTIVE;
    end
  end

  assign field_d = (!i_main_pwr || i_bus_rst) ? `FPSM_PS_D0 :
                   legal ? req : field_q;

  assign soft_d = (!i_main_pwr || i_bus_rst) ? 1'b0 :
                  from_d3_d0 ? 1'b1 : (soft_done ? 1'b0 : soft_q);
  assign soft_cnt_d = from_d3_d0 ? CW'(SOFT_RST_CYC - 1) :
                      (soft_cnt_q != '0) ? soft_cnt_q - 1'b1 : soft_cnt_q;

  // restore window opens on a write or bus reset, ends at D0 active
  assign restoring_d = (i_bus_rst || legal) ? 1'b1 :
                       (state_d == FPSM_D0_ACTIVE || !i_main_pwr) ? 1'b0 :
                       restoring_q;

  // wake context survives soft reset and aux-powered D3cold
  assign wake_en_d = (i_bus_rst && state_q != FPSM_D3_COLD) ? 1'b0 :
                     i_wake_event_enable;
  // set wins over clear
  assign wake_st_d = (wake_en_q && i_wake_event) ? 1'b1 :
                     (i_bus_rst && state_q != FPSM_D3_COLD) ? 1'b0 :
                     wake_st_q;

  assign o_state = state_q;
  assign o_power_state_field = field_q;
  assign o_drivers_off = drv_off_q;
  assign o_soft_rst = soft_q;
  assign o_recovering = rec_busy;
  assign o_restoring = restoring_q;
  assign o_wake_event_enable = wake_en_q;
  assign o_wake_status = wake_st_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= FPSM_D0_UNINIT;
      field_q <= `FPSM_PS_D0;
      soft_q <= 1'b0;
      soft_cnt_q <= '0;
      drv_off_q <= 1'b1;
      restoring_q <= 1'b1;
      wake_en_q <= 1'b0;
      wake_st_q <= 1'b0;
    end else begin
      state_q <= state_d;
      field_q <= field_d;
      soft_q <= soft_d;
      soft_cnt_q <= soft_cnt_d;
      // drivers off as under card reset
      drv_off_q <= soft_d || i_bus_rst || !i_main_pwr ||
                   state_d == FPSM_OFF || state_d == FPSM_D3_COLD;
      restoring_q <= restoring_d;
      wake_en_q <= wake_en_d;
      wake_st_q <= wake_st_d;
    end
  end
endmodule

// [fpsm_props.sv]
`timescale 1ns/1ns
module fpsm_props (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_bus_rst,
  input wire logic i_main_pwr,
  input wire logic i_aux_pwr,
  input wire fpsm_pkg::fpsm_ps_wr_t i_ps_wr,
  input wire fpsm_pkg::fpsm_enables_t i_enables,
  input wire fpsm_pkg::fpsm_state_t o_state,
  input wire logic o_soft_rst,
  input wire logic o_drivers_off
);
  import fpsm_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic pwr_ok = i_main_pwr && !i_bus_rst;
  // past terms mask a state update that lags its cause by one edge
  a_sw_only: assert property (
    !i_ps_wr.valid && !$past(i_ps_wr.valid) && pwr_ok && !o_soft_rst &&
    !$past(o_soft_rst) && o_state != FPSM_D0_UNINIT |=> $stable(o_state))
    else $error("state moved with no cause");
  a_bus_reset: assert property (pwr_ok == 1'b0 && i_main_pwr
    |=> o_state == FPSM_D0_UNINIT) else $error("bus reset ignored");
  a_power_off: assert property (!i_main_pwr && !i_aux_pwr
    |=> o_state == FPSM_OFF) else $error("power loss ignored");
  a_cold_aux: assert property (!i_main_pwr && i_aux_pwr &&
    o_state == FPSM_D3_HOT |=> o_state == FPSM_D3_COLD)
    else $error("no cold entry");
  a_enable_act: assert property (pwr_ok && i_enables != 3'h0 &&
    !i_ps_wr.valid && !o_soft_rst && o_state == FPSM_D0_UNINIT
    |=> o_state == FPSM_D0_ACTIVE) else $error("enable ignored");
  a_soft_reset: assert property (pwr_ok && i_ps_wr.valid &&
    i_ps_wr.state == 2'h0 && o_state == FPSM_D3_HOT && !o_soft_rst
    |-> ##[1:2] o_soft_rst && o_drivers_off) else $error("no soft reset");
  a_illegal_move: assert property (pwr_ok && i_ps_wr.valid &&
    i_ps_wr.state == 2'h1 && o_state == FPSM_D2
    |=> o_state == FPSM_D2 ##1 o_state == FPSM_D2)
    else $error("illegal move taken");
  a_drivers_off: assert property (o_soft_rst |-> o_drivers_off)
    else $error("drivers on in soft reset");
endmodule

// [fpsm_host_model.sv]
`timescale 1ns/1ns
module fpsm_host_model (
  input wire logic i_clock,
  input wire logic i_recovering,
  input wire logic i_bus_rst,
  output fpsm_pkg::fpsm_ps_wr_t o_ps_wr,
  output logic o_late
);
  import fpsm_pkg::*;
  initial begin
    o_ps_wr = 3'h0;
    o_late = 1'b0;
  end
  task automatic wr(logic [1:0] s);
    int n = 0;
    while ((i_recovering || i_bus_rst) && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 200) o_late = 1'b1;
    @(negedge i_clock);
    o_ps_wr = {1'b1, s};
    @(negedge i_clock);
    // idle field shows the inverse so a stale value is never trusted
    o_ps_wr = {1'b0, ~s};
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import fpsm_pkg::*;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_bus_rst = 1'b0;
  logic i_main_pwr = 1'b1, i_aux_pwr = 1'b0, late;
  logic i_wake_event_enable = 1'b0, i_wake_event = 1'b0;
  fpsm_enables_t i_enables = 3'h0;
  fpsm_ps_wr_t i_ps_wr;
  fpsm_state_t o_state;
  logic o_soft_rst, o_drivers_off, o_recovering, o_restoring;
  logic [1:0] field;
  logic wake_en, wake_st;
  int err_count = 0, compares = 0;
  always #2 i_clock = ~i_clock;
  fpsm_power_state_machine #(.D2_REC_CYC(20), .D3_REC_CYC(100),
    .SOFT_RST_CYC(4)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_bus_rst(i_bus_rst), .i_main_pwr(i_main_pwr), .i_aux_pwr(i_aux_pwr),
    .i_ps_wr(i_ps_wr), .i_enables(i_enables), .i_wake_event(i_wake_event),
    .i_wake_event_enable(i_wake_event_enable), .o_state(o_state),
    .o_power_state_field(field), .o_drivers_off(o_drivers_off),
    .o_soft_rst(o_soft_rst), .o_recovering(o_recovering),
    .o_restoring(o_restoring), .o_wake_event_enable(wake_en),
    .o_wake_status(wake_st));
  fpsm_host_model host (.i_clock(i_clock), .i_recovering(o_recovering),
    .i_bus_rst(i_bus_rst), .o_ps_wr(i_ps_wr), .o_late(late));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_start();
    cyc(8);
    chk(o_state, FPSM_D0_UNINIT);
    chk(o_drivers_off, 1'b1);
    i_sys_rst = 1'b0;
    i_enables = 3'h4;
    cyc(2);
    chk(o_state, FPSM_D0_ACTIVE);
    chk(o_restoring, 1'b0);
  endtask
  task automatic t_moves();
    logic [1:0] req [4] = '{2'h1, 2'h2, 2'h1, 2'h3};
    fpsm_state_t exp [4] = '{FPSM_D1, FPSM_D2, FPSM_D2, FPSM_D3_HOT};
    logic [1:0] exp_f [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    for (int k = 0; k < 4; k++) begin
      host.wr(req[k]);
      cyc(2);
      chk(o_state, exp[k]);
      chk(field, exp_f[k]);
    end
  endtask
  task automatic t_soft();
    // enables held off so the soft reset end state stays visible
    i_enables = 3'h0;
    host.wr(2'h0);
    cyc(1);
    chk(o_soft_rst, 1'b1);
    chk(o_drivers_off, 1'b1);
    cyc(8);
    chk(o_state, FPSM_D0_UNINIT);
    chk(o_drivers_off, 1'b0);
  endtask
  task automatic t_bus();
    i_enables = 3'h2;
    cyc(2);
    host.wr(2'h1);
    cyc(2);
    i_bus_rst = 1'b1;
    cyc(2);
    chk(o_state, FPSM_D0_UNINIT);
    chk(o_restoring, 1'b1);
    i_bus_rst = 1'b0;
    cyc(2);
  endtask
  task automatic t_power();
    host.wr(2'h3);
    cyc(2);
    i_aux_pwr = 1'b1;
    i_main_pwr = 1'b0;
    cyc(2);
    chk(o_state, FPSM_D3_COLD);
    i_main_pwr = 1'b1;
    host.wr(2'h0);
    cyc(2);
    chk(o_state, FPSM_D3_COLD);
    i_aux_pwr = 1'b0;
    i_main_pwr = 1'b0;
    cyc(2);
    chk(o_state, FPSM_OFF);
    i_main_pwr = 1'b1;
    cyc(2);
    chk(o_state, FPSM_OFF);
    i_bus_rst = 1'b1;
    cyc(2);
    chk(o_state, FPSM_D0_UNINIT);
    i_bus_rst = 1'b0;
    cyc(2);
  endtask
  task automatic t_wake();
    i_wake_event_enable = 1'b1;
    cyc(2);
    chk(wake_en, 1'b1);
    i_wake_event = 1'b1;
    cyc(1);
    i_wake_event = 1'b0;
    cyc(1);
    chk(wake_st, 1'b1);
    i_bus_rst = 1'b1;
    cyc(2);
    chk(wake_st, 1'b0);
    chk(wake_en, 1'b0);
    chk(field, 2'h0);
    i_bus_rst = 1'b0;
    i_wake_event_enable = 1'b0;
    cyc(2);
  endtask
  initial begin
    t_start();
    t_moves();
    t_soft();
    t_bus();
    t_power();
    t_wake();
    chk(late, 1'b0);
    complete_run();
  end
endmodule
bind fpsm_power_state_machine fpsm_props props (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_bus_rst(i_bus_rst), .i_main_pwr(i_main_pwr),
  .i_aux_pwr(i_aux_pwr), .i_ps_wr(i_ps_wr), .i_enables(i_enables),
  .o_state(o_state), .o_soft_rst(o_soft_rst), .o_drivers_off(o_drivers_off));
